// file: rtl/pmsc_regs.svh
// Constants for the PCI mode select and configuration data block
`ifndef PMSC_REGS_SVH
`define PMSC_REGS_SVH

// ****************************************
// PCI bus command codes
// ****************************************
`define PMSC_CMD_INTA    4'h0
`define PMSC_CMD_SPECIAL 4'h1
`define PMSC_CMD_IO_RD   4'h2
`define PMSC_CMD_IO_WR   4'h3
`define PMSC_CMD_MEM_RD  4'h6
`define PMSC_CMD_MEM_WR  4'h7
`define PMSC_CMD_CFG_RD  4'ha
`define PMSC_CMD_CFG_WR  4'hb
`define PMSC_CMD_MEM_RDM 4'hc
`define PMSC_CMD_DAC     4'hd
`define PMSC_CMD_MEM_RDL 4'he
`define PMSC_CMD_MEM_WRI 4'hf

// ****************************************
// Configuration data field and strap codes
// ****************************************
`define PMSC_CFG_DATA_MSB 31
`define PMSC_CFG_DATA_LSB 0
`define PMSC_STRAP_HOST_EXT 2'h0
`define PMSC_STRAP_HOST_FB  2'h1
`define PMSC_STRAP_NON_HOST 2'h2
`define PMSC_STRAP_DISABLED 2'h3

`endif

// file: rtl/pmsc_pkg.sv
// Types shared by the PCI mode select and configuration data block
package pmsc_pkg;

  typedef enum logic [1:0] {
    PMSC_HOST_EXT,
    PMSC_HOST_FB,
    PMSC_NON_HOST,
    PMSC_DISABLED
  } pmsc_mode_t;

  typedef enum logic [1:0] {
    PMSC_C_IDLE,
    PMSC_C_WAIT,
    PMSC_C_ACK
  } pmsc_core_st_t;

  typedef enum logic {
    PMSC_L_IDLE,
    PMSC_L_BUSY
  } pmsc_link_st_t;

endpackage : pmsc_pkg

// file: rtl/pmsc_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module pmsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : pmsc_sync

// file: rtl/pmsc_cmd_filter.sv
// PCI command filter for master issue and target claim
`timescale 1ns/1ps
`include "pmsc_regs.svh"
module pmsc_cmd_filter (
  input  wire logic       host_en_in,
  input  wire logic       non_host_in,
  input  wire logic [3:0] tgt_cmd_in,
  input  wire logic [3:0] mst_cmd_in,
  output logic            tgt_ok_out,
  output logic      [3:0] tgt_eff_out,
  output logic            mst_ok_out
);
  wire active   = host_en_in | non_host_in;
  wire t_basic  = (tgt_cmd_in == `PMSC_CMD_MEM_RD)
                | (tgt_cmd_in == `PMSC_CMD_MEM_WR)
                | (tgt_cmd_in == `PMSC_CMD_IO_RD)
                | (tgt_cmd_in == `PMSC_CMD_IO_WR);
  wire t_rd_alias = (tgt_cmd_in == `PMSC_CMD_MEM_RDL)
                  | (tgt_cmd_in == `PMSC_CMD_MEM_RDM);
  wire t_wr_alias = (tgt_cmd_in == `PMSC_CMD_MEM_WRI);
  wire t_cfg    = (tgt_cmd_in == `PMSC_CMD_CFG_RD)
                | (tgt_cmd_in == `PMSC_CMD_CFG_WR);
  wire m_basic  = (mst_cmd_in == `PMSC_CMD_MEM_RD)
                | (mst_cmd_in == `PMSC_CMD_MEM_WR)
                | (mst_cmd_in == `PMSC_CMD_IO_RD)
                | (mst_cmd_in == `PMSC_CMD_IO_WR);
  wire m_host   = (mst_cmd_in == `PMSC_CMD_CFG_RD)
                | (mst_cmd_in == `PMSC_CMD_CFG_WR)
                | (mst_cmd_in == `PMSC_CMD_SPECIAL);

  // Interrupt acknowledge, dual address and special never claimed
  assign tgt_ok_out  = active & (t_basic | t_rd_alias | t_wr_alias
                     | (t_cfg & non_host_in));
  assign tgt_eff_out = t_rd_alias ? `PMSC_CMD_MEM_RD :
                       t_wr_alias ? `PMSC_CMD_MEM_WR : tgt_cmd_in;
  assign mst_ok_out  = active & (m_basic | (m_host & host_en_in));
endmodule : pmsc_cmd_filter

// file: rtl/pmsc_top.sv
// PCI mode select, command filter and configuration data register
`timescale 1ns/1ps
`include "pmsc_regs.svh"
module pmsc_top #(
  parameter int DATA_W = 32
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              host_select_strap_in,
  input  wire logic              clock_select_strap_in,
  input  wire logic              pp_req_in,
  input  wire logic              pp_wr_in,
  input  wire logic              pp_long_in,
  input  wire logic [DATA_W-1:0] pp_wdata_in,
  input  wire logic [31:0]       pio_addr_in,
  output logic      [DATA_W-1:0] pp_rdata_out,
  output logic                   pp_ack_out,
  output logic                   host_en_out,
  output logic                   non_host_out,
  output logic                   disabled_out,
  output logic                   pci_clk_sel_out,
  input  wire logic              pci_clk_in,
  input  wire logic              pci_rst_in,
  output logic                   cfg_start_out,
  output logic      [3:0]        cfg_cmd_out,
  output logic      [31:0]       cfg_addr_out,
  output logic      [DATA_W-1:0] cfg_wdata_out,
  input  wire logic              cfg_done_in,
  input  wire logic [DATA_W-1:0] cfg_rdata_in,
  input  wire logic              tgt_valid_in,
  input  wire logic [3:0]        tgt_cmd_in,
  output logic                   tgt_claim_out,
  output logic      [3:0]        tgt_cmd_out,
  input  wire logic              mst_req_in,
  input  wire logic [3:0]        mst_cmd_in,
  output logic                   mst_go_out,
  output logic      [3:0]        mst_cmd_out
);

  // ****************************************
  // Strap capture and operating mode
  // ****************************************
  logic [1:0]          strap_s;
  logic                mode_valid_q;
  pmsc_pkg::pmsc_mode_t mode_q;

  pmsc_sync #(.WIDTH(2)) u_strap_sync (
    .clk_in (core_clk_in),
    .rst_in (1'b0),
    .d_in   ({host_select_strap_in, clock_select_strap_in}),
    .q_out  (strap_s)
  );

  wire pmsc_pkg::pmsc_mode_t strap_mode =
    pmsc_pkg::pmsc_mode_t'(strap_s);

  // Caught once on the first edge after release, then frozen
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mode_valid_q <= 1'b0;
      mode_q       <= pmsc_pkg::PMSC_DISABLED;
    end else if (!mode_valid_q) begin
      mode_valid_q <= 1'b1;
      mode_q       <= strap_mode;
    end
  end

  wire host_mode = mode_valid_q
    & ((mode_q == pmsc_pkg::PMSC_HOST_EXT)
    |  (mode_q == pmsc_pkg::PMSC_HOST_FB));
  wire nonhost_mode = mode_valid_q
    & (mode_q == pmsc_pkg::PMSC_NON_HOST);
  wire dis_mode = !mode_valid_q
    | (mode_q == pmsc_pkg::PMSC_DISABLED);
  wire clk_fb   = mode_valid_q
    & (mode_q == pmsc_pkg::PMSC_HOST_FB);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      host_en_out     <= 1'b0;
      non_host_out    <= 1'b0;
      disabled_out    <= 1'b1;
      pci_clk_sel_out <= 1'b0;
    end else begin
      host_en_out     <= host_mode;
      non_host_out    <= nonhost_mode;
      disabled_out    <= dis_mode;
      pci_clk_sel_out <= clk_fb;
    end
  end

  // ****************************************
  // Peripheral bus side of the data register
  // ****************************************
  pmsc_pkg::pmsc_core_st_t cst_q;
  logic [DATA_W-1:0]       data_q;
  logic [31:0]             addr_q;
  logic                    cfg_wr_q;
  logic                    req_tgl_q;
  logic                    ack_tgl_s;
  logic                    ack_tgl_q;
  logic [DATA_W-1:0]       link_rdata_q;

  wire pending  = req_tgl_q != ack_tgl_s;
  wire take     = pp_req_in & (cst_q == pmsc_pkg::PMSC_C_IDLE) & !pending;
  // Odd sizes and a dead controller read zero and drop writes
  wire bad_acc  = !pp_long_in | dis_mode;
  wire launch   = take & !bad_acc & host_mode;
  wire rd_launch = launch & !pp_wr_in;
  wire wr_take  = take & !bad_acc & pp_wr_in;
  wire rd_local = take & !bad_acc & !pp_wr_in & !host_mode;
  wire rd_done  = (cst_q == pmsc_pkg::PMSC_C_WAIT) & !pending;

  pmsc_sync #(.WIDTH(1)) u_ack_sync (
    .clk_in (core_clk_in),
    .rst_in (rst_in),
    .d_in   (ack_tgl_q),
    .q_out  (ack_tgl_s)
  );

  // No reset on purpose: content stays across both resets
  always_ff @(posedge core_clk_in) begin
    if (wr_take) begin
      data_q <= pp_wdata_in;
    end else if (rd_done) begin
      data_q <= link_rdata_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cst_q        <= pmsc_pkg::PMSC_C_IDLE;
      req_tgl_q    <= 1'b0;
      cfg_wr_q     <= 1'b0;
      addr_q       <= '0;
      pp_ack_out   <= 1'b0;
      pp_rdata_out <= '0;
    end else begin
      pp_ack_out <= 1'b0;
      if (launch) begin
        req_tgl_q <= !req_tgl_q;
        cfg_wr_q  <= pp_wr_in;
        addr_q    <= pio_addr_in;
      end
      case (cst_q)
        pmsc_pkg::PMSC_C_IDLE: begin
          if (rd_launch) begin
            cst_q <= pmsc_pkg::PMSC_C_WAIT;
          end else if (take) begin
            // Write ends once latched; in host mode the cycle runs on behind
            pp_ack_out   <= 1'b1;
            pp_rdata_out <= rd_local ? data_q : '0;
            cst_q        <= pmsc_pkg::PMSC_C_ACK;
          end
        end
        pmsc_pkg::PMSC_C_WAIT: begin
          if (rd_done) begin
            pp_ack_out   <= 1'b1;
            pp_rdata_out <= link_rdata_q;
            cst_q        <= pmsc_pkg::PMSC_C_ACK;
          end
        end
        pmsc_pkg::PMSC_C_ACK: begin
          // Gap cycle so a request still high is not taken twice
          cst_q <= pmsc_pkg::PMSC_C_IDLE;
        end
        default: begin
          cst_q <= pmsc_pkg::PMSC_C_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Link side: configuration cycles and filter
  // ****************************************
  pmsc_pkg::pmsc_link_st_t lst_q;
  logic [2:0]              lmode_s;
  logic                    req_tgl_s;
  logic                    seen_q;
  logic                    tgt_ok;
  logic [3:0]              tgt_eff;
  logic                    mst_ok;

  pmsc_sync #(.WIDTH(1)) u_req_sync (
    .clk_in (pci_clk_in),
    .rst_in (pci_rst_in),
    .d_in   (req_tgl_q),
    .q_out  (req_tgl_s)
  );

  pmsc_sync #(.WIDTH(3)) u_mode_sync (
    .clk_in (pci_clk_in),
    .rst_in (pci_rst_in),
    .d_in   ({host_en_out, non_host_out, disabled_out}),
    .q_out  (lmode_s)
  );

  wire l_host    = lmode_s[2];
  wire l_nonhost = lmode_s[1];
  wire new_req   = (req_tgl_s != seen_q) & (lst_q == pmsc_pkg::PMSC_L_IDLE);

  pmsc_cmd_filter u_filter (
    .host_en_in  (l_host),
    .non_host_in (l_nonhost),
    .tgt_cmd_in  (tgt_cmd_in),
    .mst_cmd_in  (mst_cmd_in),
    .tgt_ok_out  (tgt_ok),
    .tgt_eff_out (tgt_eff),
    .mst_ok_out  (mst_ok)
  );

  // Core holds address and data stable until the ack toggle returns
  always_ff @(posedge pci_clk_in) begin
    if (pci_rst_in) begin
      lst_q         <= pmsc_pkg::PMSC_L_IDLE;
      seen_q        <= 1'b0;
      ack_tgl_q     <= 1'b0;
      link_rdata_q  <= '0;
      cfg_start_out <= 1'b0;
      cfg_cmd_out   <= `PMSC_CMD_CFG_RD;
      cfg_addr_out  <= '0;
      cfg_wdata_out <= '0;
    end else begin
      cfg_start_out <= 1'b0;
      case (lst_q)
        pmsc_pkg::PMSC_L_IDLE: begin
          if (new_req) begin
            seen_q        <= req_tgl_s;
            cfg_start_out <= 1'b1;
            cfg_cmd_out   <= cfg_wr_q ? `PMSC_CMD_CFG_WR
                                      : `PMSC_CMD_CFG_RD;
            cfg_addr_out  <= addr_q;
            cfg_wdata_out <= data_q;
            lst_q         <= pmsc_pkg::PMSC_L_BUSY;
          end
        end
        pmsc_pkg::PMSC_L_BUSY: begin
          if (cfg_done_in) begin
            link_rdata_q <= cfg_rdata_in;
            ack_tgl_q    <= !ack_tgl_q;
            lst_q        <= pmsc_pkg::PMSC_L_IDLE;
          end
        end
        default: begin
          lst_q <= pmsc_pkg::PMSC_L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pci_clk_in) begin
    if (pci_rst_in) begin
      tgt_claim_out <= 1'b0;
      tgt_cmd_out   <= `PMSC_CMD_MEM_RD;
      mst_go_out    <= 1'b0;
      mst_cmd_out   <= `PMSC_CMD_MEM_RD;
    end else begin
      tgt_claim_out <= tgt_valid_in & tgt_ok;
      tgt_cmd_out   <= tgt_eff;
      mst_go_out    <= mst_req_in & mst_ok;
      mst_cmd_out   <= mst_cmd_in;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  mode_hold_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    $past(mode_valid_q) |-> $stable(mode_q))
    else $error("Operating mode changed after capture");

  host_ext_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    mode_valid_q && mode_q == pmsc_pkg::PMSC_HOST_EXT
    |=> host_en_out && !pci_clk_sel_out && !non_host_out)
    else $error("Straps 00 not decoded as host with external clock");

  host_fb_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    mode_valid_q && mode_q == pmsc_pkg::PMSC_HOST_FB
    |=> host_en_out && pci_clk_sel_out)
    else $error("Straps 01 not decoded as host with feedback clock");

  non_host_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    mode_valid_q && mode_q == pmsc_pkg::PMSC_NON_HOST
    |=> non_host_out && !host_en_out && !pci_clk_sel_out)
    else $error("Straps 10 not decoded as non-host");

  dis_quiet_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    dis_mode |=> disabled_out && $stable(req_tgl_q))
    else $error("Disabled controller launched a cycle");

  rd_launch_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    rd_launch |=> req_tgl_q != $past(req_tgl_q) && !cfg_wr_q
    && cst_q == pmsc_pkg::PMSC_C_WAIT)
    else $error("Data register read did not launch a read cycle");

  wr_store_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    wr_take |=> data_q == $past(pp_wdata_in) ##1 pp_ack_out == 1'b0)
    else $error("Data register write not stored");

  rd_return_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    rd_done |=> pp_ack_out && pp_rdata_out == $past(link_rdata_q)
    && data_q == $past(link_rdata_q))
    else $error("Read did not return captured configuration data");

  rd_stall_a: assert property (
    @(posedge core_clk_in) disable iff (rst_in)
    cst_q == pmsc_pkg::PMSC_C_WAIT && pending |=> !pp_ack_out)
    else $error("Read answered before configuration data arrived");

  cfg_host_a: assert property (
    @(posedge pci_clk_in) disable iff (pci_rst_in)
    mst_go_out && (mst_cmd_out == `PMSC_CMD_CFG_RD
    || mst_cmd_out == `PMSC_CMD_CFG_WR
    || mst_cmd_out == `PMSC_CMD_SPECIAL) |-> $past(l_host))
    else $error("Host-only command issued outside host mode");

  mst_legal_a: assert property (
    @(posedge pci_clk_in) disable iff (pci_rst_in)
    mst_go_out |-> mst_cmd_out != `PMSC_CMD_MEM_RDL
    && mst_cmd_out != `PMSC_CMD_MEM_RDM && mst_cmd_out != `PMSC_CMD_MEM_WRI
    && mst_cmd_out != `PMSC_CMD_INTA && mst_cmd_out != `PMSC_CMD_DAC)
    else $error("Forbidden master command issued");

  tgt_alias_a: assert property (
    @(posedge pci_clk_in) disable iff (pci_rst_in)
    tgt_valid_in && (l_host || l_nonhost) && (tgt_cmd_in ==
    `PMSC_CMD_MEM_RDL || tgt_cmd_in == `PMSC_CMD_MEM_RDM)
    |=> tgt_claim_out && tgt_cmd_out == `PMSC_CMD_MEM_RD)
    else $error("Read line or multiple not taken as memory read");

  tgt_cfg_a: assert property (
    @(posedge pci_clk_in) disable iff (pci_rst_in)
    tgt_valid_in && tgt_cmd_in == `PMSC_CMD_CFG_WR
    |=> tgt_claim_out == $past(l_nonhost))
    else $error("Configuration target claim wrong for mode");

endmodule : pmsc_top

// file: bench/pmsc_far_model.sv
// Far-side agent that answers configuration cycles on the link
`timescale 1ns/1ps
module pmsc_far_model (
  input  wire logic        pci_clk_in,
  input  wire logic        pci_rst_in,
  input  wire logic        cfg_start_in,
  input  wire logic [3:0]  cfg_cmd_in,
  input  wire logic [31:0] cfg_addr_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic [31:0] rd_value_in,
  input  wire logic [3:0]  lat_in,
  output logic             cfg_done_out,
  output logic      [31:0] cfg_rdata_out
);
  int          starts = 0;
  int          wait_cnt = 0;
  logic        busy = 1'b0;
  logic [3:0]  seen_cmd;
  logic [31:0] seen_addr;
  logic [31:0] seen_wdata;
  initial cfg_done_out = 1'b0;
  initial cfg_rdata_out = 32'h0;
  wire fire = !pci_rst_in && !cfg_start_in && busy && (wait_cnt == 0);
  always @(posedge pci_clk_in) begin
    cfg_done_out <= fire;
    // Data is only meaningful with done, so it changes every cycle
    cfg_rdata_out <= fire ? rd_value_in : ~cfg_rdata_out;
    if (pci_rst_in) begin
      busy <= 1'b0;
    end else if (cfg_start_in) begin
      busy <= 1'b1;
      wait_cnt <= lat_in;
      starts <= starts + 1;
      seen_cmd <= cfg_cmd_in;
      seen_addr <= cfg_addr_in;
      seen_wdata <= cfg_wdata_in;
    end else if (fire) begin
      busy <= 1'b0;
    end else if (busy) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : pmsc_far_model

// file: bench/tb_top.sv
// Self-checking bench for the PCI mode select and configuration block
`timescale 1ns/1ps
module tb_top;
  logic        core_clk_in = 1'b0;
  logic        pci_clk_in = 1'b0;
  logic        rst_in, pci_rst_in, hs_q, cs_q;
  logic        pp_req_in, pp_wr_in, pp_long_in, pp_ack_out;
  logic [31:0] pp_wdata_in, pio_addr_in, pp_rdata_out, cfg_rdata_in;
  logic [31:0] cfg_addr_out, cfg_wdata_out, rd_value, a, d, r;
  // Bench copy of the data register and pending read answers
  logic [31:0] reg_m;
  logic [31:0] exp_q[$];
  logic        host_en_out, non_host_out, disabled_out, pci_clk_sel_out;
  logic        cfg_start_out, cfg_done_in, tgt_valid_in, tgt_claim_out;
  logic        mst_req_in, mst_go_out;
  logic [3:0]  cfg_cmd_out, tgt_cmd_in, tgt_cmd_out, mst_cmd_in;
  logic [3:0]  mst_cmd_out, lat;
  int          failures = 0;
  int          checks = 0;
  int          mode, s0;

  always #4 core_clk_in = ~core_clk_in;
  initial begin
    #5;
    forever #32 pci_clk_in = ~pci_clk_in;
  end

  pmsc_top i_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .host_select_strap_in(hs_q), .clock_select_strap_in(cs_q),
    .pp_req_in(pp_req_in), .pp_wr_in(pp_wr_in), .pp_long_in(pp_long_in),
    .pp_wdata_in(pp_wdata_in), .pio_addr_in(pio_addr_in),
    .pp_rdata_out(pp_rdata_out), .pp_ack_out(pp_ack_out),
    .host_en_out(host_en_out), .non_host_out(non_host_out),
    .disabled_out(disabled_out), .pci_clk_sel_out(pci_clk_sel_out),
    .pci_clk_in(pci_clk_in), .pci_rst_in(pci_rst_in),
    .cfg_start_out(cfg_start_out), .cfg_cmd_out(cfg_cmd_out),
    .cfg_addr_out(cfg_addr_out), .cfg_wdata_out(cfg_wdata_out),
    .cfg_done_in(cfg_done_in), .cfg_rdata_in(cfg_rdata_in),
    .tgt_valid_in(tgt_valid_in), .tgt_cmd_in(tgt_cmd_in),
    .tgt_claim_out(tgt_claim_out), .tgt_cmd_out(tgt_cmd_out),
    .mst_req_in(mst_req_in), .mst_cmd_in(mst_cmd_in),
    .mst_go_out(mst_go_out), .mst_cmd_out(mst_cmd_out));

  pmsc_far_model i_far (
    .pci_clk_in(pci_clk_in), .pci_rst_in(pci_rst_in),
    .cfg_start_in(cfg_start_out), .cfg_cmd_in(cfg_cmd_out),
    .cfg_addr_in(cfg_addr_out), .cfg_wdata_in(cfg_wdata_out),
    .rd_value_in(rd_value), .lat_in(lat),
    .cfg_done_out(cfg_done_in), .cfg_rdata_out(cfg_rdata_in));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  // Both resets overlap; straps stay put while reset is held
  task automatic do_reset(input int m);
    @(negedge pci_clk_in);
    mode = m;
    hs_q = m[1];
    cs_q = m[0];
    pci_rst_in = 1'b1;
    @(negedge core_clk_in);
    rst_in = 1'b1;
    repeat (3) @(negedge pci_clk_in);
    pci_rst_in = 1'b0;
    @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (6) @(negedge pci_clk_in);
    check(host_en_out, m < 2);
    check(non_host_out, m == 2);
    check(disabled_out, m == 3);
    check(pci_clk_sel_out, m == 1);
  endtask : do_reset

  task automatic pp_access(input logic wr, input logic lng,
                           input logic [31:0] wd, input logic [31:0] ad,
                           output logic [31:0] rd);
    int n;
    @(negedge core_clk_in);
    pp_req_in = 1'b1;
    pp_wr_in = wr;
    pp_long_in = lng;
    pp_wdata_in = wd;
    pio_addr_in = ad;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (pp_ack_out !== 1'b1 && n < 400);
    if (n >= 400) failures++;
    rd = pp_rdata_out;
    // Request stands through the edge that samples the ack
    @(negedge core_clk_in);
    pp_req_in = 1'b0;
  endtask : pp_access

  // Every command back to back on both filter paths
  task automatic filter_sweep();
    logic [3:0] c;
    logic       cl;
    logic       go;
    for (int i = 0; i <= 16; i++) begin
      @(negedge pci_clk_in);
      if (i > 0) begin
        cl = (mode != 3) && (c inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he,
             4'hf} || (mode == 2 && c inside {4'ha, 4'hb}));
        go = (mode != 3) && (c inside {4'h2, 4'h3, 4'h6, 4'h7} ||
             (mode < 2 && c inside {4'h1, 4'ha, 4'hb}));
        check(tgt_claim_out, cl);
        check(mst_go_out, go);
        if (cl) check(tgt_cmd_out, (c == 4'hc || c == 4'he) ? 4'h6 :
                      (c == 4'hf) ? 4'h7 : c);
        if (go) check(mst_cmd_out, c);
      end
      c = i[3:0];
      tgt_valid_in = (i < 16);
      mst_req_in = (i < 16);
      tgt_cmd_in = c;
      mst_cmd_in = c;
    end
    @(negedge pci_clk_in);
    check(tgt_claim_out, 1'b0);
    check(mst_go_out, 1'b0);
  endtask : filter_sweep

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_in, pci_rst_in, hs_q, cs_q} = 4'hf;
    {pp_req_in, pp_wr_in, pp_long_in, tgt_valid_in, mst_req_in} = 5'h0;
    {pp_wdata_in, pio_addr_in, rd_value} = 96'h0;
    {tgt_cmd_in, mst_cmd_in, lat} = 12'h0;
    void'($urandom(32'ha96b75ba));
    do_reset(0);
    filter_sweep();
    a = $urandom;
    d = $urandom;
    s0 = i_far.starts;
    pp_access(1'b1, 1'b1, d, a, r);
    while (i_far.starts == s0) @(negedge core_clk_in);
    check(i_far.seen_cmd, 4'hb);
    check(i_far.seen_addr, a);
    check(i_far.seen_wdata, d);
    for (int k = 0; k < 3; k++) begin
      lat = (k == 0) ? 4'h0 : 4'(($urandom % 15) + 1);
      rd_value = $urandom;
      exp_q.push_back(rd_value);
      s0 = i_far.starts;
      pp_access(1'b0, 1'b1, 32'h0, a + k, r);
      check(r, exp_q.pop_front());
      check(i_far.seen_cmd, 4'ha);
      check(i_far.seen_addr, a + k);
      check(i_far.starts, s0 + 1);
    end
    s0 = i_far.starts;
    pp_access(1'b0, 1'b0, 32'h0, a, r);
    check(r, 32'h0);
    check(i_far.starts, s0);
    do_reset(1);
    filter_sweep();
    do_reset(2);
    filter_sweep();
    d = $urandom;
    s0 = i_far.starts;
    pp_access(1'b1, 1'b1, d, a, r);
    reg_m = d;
    pp_access(1'b1, 1'b0, ~d, a, r);
    pp_access(1'b0, 1'b1, 32'h0, a, r);
    check(r, reg_m);
    check(i_far.starts, s0);
    do_reset(2);
    pp_access(1'b0, 1'b1, 32'h0, a, r);
    check(r, reg_m);
    // No register access at all while disabled
    do_reset(3);
    filter_sweep();
    end_sim();
  end

  initial begin
    #300000;
    failures++;
    end_sim();
  end
endmodule : tb_top
